/* xlate_init_consts.svh */
// Offsets, field positions, opcodes and timing counts of the init block
`ifndef XLATE_INIT_CONSTS_SVH
`define XLATE_INIT_CONSTS_SVH

// Register offsets (byte addresses, one word each)
`define OFS_CONTROL_ZERO 8'h00
`define OFS_CONTROL_ACK 8'h04
`define OFS_SECURE_INIT 8'h08
`define OFS_STATUS 8'h0c
`define OFS_CMDQ_PROD 8'h10
`define OFS_CMDQ_CONS 8'h14
`define OFS_EVTQ_PROD 8'h18
`define OFS_EVTQ_CONS 8'h1c
`define OFS_CMD_SUBMIT 8'h20
`define OFS_STE_LO 8'h24
`define OFS_STE_HI 8'h28
`define OFS_CD_WORD 8'h2c
`define OFS_DECODE 8'h30
`define OFS_SEL_ID 8'h34

// Control register zero / ack bit positions
`define BIT_UNIT_ENABLE 0
`define BIT_EVENTQ_ENABLE 2
`define BIT_CMDQ_ENABLE 3
// Secure init bit position
`define BIT_INV_EVERYTHING 0
// Command submit fields
`define BIT_CMD_SECURE 8
`define CMD_OP_MSB 7

// Command opcodes
`define OP_TLB_NS_EL1 8'h30
`define OP_TLB_HYP 8'h20
`define OP_TLB_MON 8'h18
`define OP_TLB_S_EL1 8'h10
`define OP_CFG_INVALIDATE_EVERYTHING_BIT 8'h04
`define OP_SYNC 8'h46

// Stream entry low word fields
`define STE_CFG_LSB 1
`define STE_FMT_LSB 4
`define STE_CDMAX_LSB 6
`define STE_TG_LSB 11
`define STE_IR_LSB 13
`define STE_OR_LSB 15
`define STE_SH_LSB 17
`define STE_AFFD_BIT 19
// Stream entry high word: VM tag in low 16 bits
`define STE_VMID_W 16
// Context descriptor word fields
`define CD_VALID_BIT 0
`define CD_FMT_BIT 1
`define CD_WDIS0_BIT 2
`define CD_ASID_SET_SELECT_BIT 3

// Structure size in bytes, 64 for both kinds
`define ENTRY_BYTES 64

// Timing: an invalidation sweep and enable latency, in ns
`define INV_TIME_NS 64
`define INV_CYCLES ((`INV_TIME_NS + 3) / 4)
`define EN_TIME_NS 8
`define EN_CYCLES ((`EN_TIME_NS + 3) / 4)

`endif

/* xlate_init_pkg.sv */
// Types shared by the translation init block
package xlate_init_pkg;
   typedef enum logic [1:0] {
      mode_abort,
      mode_bypass,
      mode_stage1,
      mode_stage2
   } ste_mode_e;
   typedef enum logic [1:0] {
      gran_4k,
      gran_64k,
      gran_16k,
      gran_bad
   } granule_e;
   typedef enum {
      inv_idle,
      inv_run,
      inv_done
   } inv_state_e;
endpackage

/* translation_unit_init_config.sv */
// Init, enable and configuration decode of the translation unit
`timescale 1ns/10ps
`include "xlate_init_consts.svh"
module translation_unit_init_config #(
   parameter int QIDX_W = 8,
   parameter int ID_W = 16
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_sec_override,
   input wire logic i_access_secure,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic [ID_W-1:0] i_stream_id,
   input wire logic [ID_W-1:0] i_substream_id,
   output logic [ID_W+5:0] o_ste_addr,
   output logic [ID_W+5:0] o_cd_addr,
   output logic o_abort,
   output logic o_stage1_en,
   output logic o_stage2_en,
   output logic o_walk0_en,
   output logic o_cd_is_table,
   output logic o_cd_ptr_ipa,
   output logic o_af_fault_suppress,
   output logic [15:0] o_vm_tag,
   output logic o_flush_walk_cache,
   output logic o_flush_buffer_units,
   output logic o_cmdq_empty,
   output logic o_evtq_empty
);
   initial begin
      if (QIDX_W < 1 || QIDX_W > 20) begin
         $error("QIDX_W out of range");
      end
      if (ID_W < 1 || ID_W > 24) begin
         $error("ID_W out of range");
      end
   end

   localparam int OFS_W = $clog2(`ENTRY_BYTES);
   localparam logic [4:0] INV_N = 5'(`INV_CYCLES);
   localparam logic [3:0] EN_N = 4'(`EN_CYCLES);

   logic [31:0] control_zero;
   logic [31:0] control_ack;
   logic inv_everything;
   logic [31:0] ste_lo;
   logic [15:0] ste_hi;
   logic [31:0] cd_word;
   logic [QIDX_W-1:0] cmdq_prod;
   logic [QIDX_W-1:0] cmdq_cons;
   logic [QIDX_W-1:0] evtq_prod;
   logic [QIDX_W-1:0] evtq_cons;
   logic [4:0] inv_count;
   logic [3:0] en_count;
   logic [4:0] pend_count;
   logic sync_done;
   logic cmd_refused;
   logic flush_pulse;
   xlate_init_pkg::inv_state_e inv_state;
   xlate_init_pkg::ste_mode_e mode;
   xlate_init_pkg::granule_e granule;
   logic [1:0] walk_inner;
   logic [1:0] walk_outer;
   logic [1:0] walk_share;

   wire logic sec_ok = i_access_secure | i_sec_override;
   wire logic wr_ctrl = i_wr && i_addr == `OFS_CONTROL_ZERO;
   wire logic wr_init = i_wr && i_addr == `OFS_SECURE_INIT && sec_ok;
   wire logic wr_cmd = i_wr && i_addr == `OFS_CMD_SUBMIT;
   wire logic [7:0] cmd_op = i_wdata[`CMD_OP_MSB:0];
   wire logic cmd_sec = i_wdata[`BIT_CMD_SECURE];

   // Classifies an opcode as a secure-only TLB flush
   function automatic logic op_secure_only(input logic [7:0] op);
      return op == `OP_TLB_S_EL1 || op == `OP_TLB_MON;
   endfunction

   // Cacheability code decode, shared by inner and outer fields
   function automatic logic [1:0] walk_cache(input logic [1:0] code);
      return (code == 2'h3) ? 2'h0 : code;
   endfunction

   // Control register zero, written as a whole word
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         control_zero <= 32'h0;
      end else if (wr_ctrl) begin
         control_zero <= i_wdata;
      end
   end

   // Acknowledge follows the control after the enable latency
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         control_ack <= 32'h0;
         en_count <= 4'h0;
      end else if (wr_ctrl) begin
         en_count <= EN_N;
      end else if (en_count > 4'h1) begin
         en_count <= en_count - 4'h1;
      end else if (en_count == 4'h1) begin
         en_count <= 4'h0;
         control_ack <= control_zero;
      end
   end

   // Global invalidate sequencer, self-clearing bit
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         inv_state <= xlate_init_pkg::inv_idle;
         inv_everything <= 1'b0;
         inv_count <= 5'h00;
      end else begin
         unique case (inv_state)
            xlate_init_pkg::inv_idle: begin
               if (wr_init && i_wdata[`BIT_INV_EVERYTHING]) begin
                  inv_everything <= 1'b1;
                  inv_count <= INV_N;
                  inv_state <= xlate_init_pkg::inv_run;
               end
            end
            xlate_init_pkg::inv_run: begin
               if (inv_count == 5'h01) begin
                  inv_state <= xlate_init_pkg::inv_done;
               end
               inv_count <= inv_count - 5'h01;
            end
            xlate_init_pkg::inv_done: begin
               inv_everything <= 1'b0;
               inv_state <= xlate_init_pkg::inv_idle;
            end
         endcase
      end
   end

   // Command execution: flush pulses, refusal and sync tracking
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         flush_pulse <= 1'b0;
         cmd_refused <= 1'b0;
         sync_done <= 1'b0;
         pend_count <= 5'h00;
      end else begin
         flush_pulse <= 1'b0;
         if (pend_count != 5'h00) begin
            pend_count <= pend_count - 5'h01;
         end
         if (wr_cmd) begin
            if (op_secure_only(cmd_op) && !cmd_sec) begin
               cmd_refused <= 1'b1;
            end else if (cmd_op == `OP_SYNC) begin
               sync_done <= (pend_count == 5'h00);
            end else begin
               pend_count <= INV_N;
               sync_done <= 1'b0;
               flush_pulse <= (cmd_op == `OP_CFG_INVALIDATE_EVERYTHING_BIT);
            end
         end else if (pend_count == 5'h01) begin
            sync_done <= 1'b1;
         end
      end
   end

   // Either global invalidate or config-invalidate-all flushes both caches
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_flush_walk_cache <= 1'b0;
         o_flush_buffer_units <= 1'b0;
      end else begin
         o_flush_walk_cache <= flush_pulse
            || inv_state == xlate_init_pkg::inv_run;
         o_flush_buffer_units <= flush_pulse
            || inv_state == xlate_init_pkg::inv_run;
      end
   end

   // Queue indices and configuration words
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         cmdq_prod <= '0;
         cmdq_cons <= '0;
         evtq_prod <= '0;
         evtq_cons <= '0;
         ste_lo <= 32'h0;
         ste_hi <= 16'h0;
         cd_word <= 32'h0;
      end else if (i_wr) begin
         unique case (i_addr)
            `OFS_CMDQ_PROD: cmdq_prod <= i_wdata[QIDX_W-1:0];
            `OFS_CMDQ_CONS: cmdq_cons <= i_wdata[QIDX_W-1:0];
            `OFS_EVTQ_PROD: evtq_prod <= i_wdata[QIDX_W-1:0];
            `OFS_EVTQ_CONS: evtq_cons <= i_wdata[QIDX_W-1:0];
            `OFS_STE_LO: ste_lo <= i_wdata;
            `OFS_STE_HI: ste_hi <= i_wdata[`STE_VMID_W-1:0];
            `OFS_CD_WORD: cd_word <= i_wdata;
            default: begin
            end
         endcase
      end
   end

   // Stream entry decode
   always_comb begin
      unique case (ste_lo[`STE_CFG_LSB +: 3])
         3'h4: mode = xlate_init_pkg::mode_bypass;
         3'h5: mode = xlate_init_pkg::mode_stage1;
         3'h6: mode = xlate_init_pkg::mode_stage2;
         3'h7: mode = xlate_init_pkg::mode_stage2;
         default: mode = xlate_init_pkg::mode_abort;
      endcase
      unique case (ste_lo[`STE_TG_LSB +: 2])
         2'h0: granule = xlate_init_pkg::gran_4k;
         2'h1: granule = xlate_init_pkg::gran_64k;
         2'h2: granule = xlate_init_pkg::gran_16k;
         default: granule = xlate_init_pkg::gran_bad;
      endcase
      walk_inner = walk_cache(ste_lo[`STE_IR_LSB +: 2]);
      walk_outer = walk_cache(ste_lo[`STE_OR_LSB +: 2]);
      walk_share = (ste_lo[`STE_SH_LSB +: 2] == 2'h3) ? 2'h0
         : ste_lo[`STE_SH_LSB +: 2];
   end

   // Registered translation controls; unknown config codes abort
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_abort <= 1'b1;
         o_stage1_en <= 1'b0;
         o_stage2_en <= 1'b0;
         o_walk0_en <= 1'b0;
         o_cd_is_table <= 1'b0;
         o_cd_ptr_ipa <= 1'b0;
         o_af_fault_suppress <= 1'b0;
         o_vm_tag <= 16'h0;
      end else begin
         o_abort <= mode == xlate_init_pkg::mode_abort;
         o_stage1_en <= ste_lo[`STE_CFG_LSB] && ste_lo[`STE_CFG_LSB+2]
            && cd_word[`CD_VALID_BIT];
         o_stage2_en <= ste_lo[`STE_CFG_LSB+1] && ste_lo[`STE_CFG_LSB+2];
         o_walk0_en <= cd_word[`CD_VALID_BIT]
            && !cd_word[`CD_WDIS0_BIT];
         o_cd_is_table <= ste_lo[`STE_CDMAX_LSB +: 5] != 5'h0;
         o_cd_ptr_ipa <= ste_lo[`STE_CFG_LSB+1]
            && ste_lo[`STE_CFG_LSB+2];
         o_af_fault_suppress <= ste_lo[`STE_AFFD_BIT];
         o_vm_tag <= ste_hi;
      end
   end

   // Entry addresses: 64-byte slots indexed by the ids
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_ste_addr <= '0;
         o_cd_addr <= '0;
      end else begin
         o_ste_addr <= {i_stream_id, OFS_W'(0)};
         o_cd_addr <= {i_substream_id, OFS_W'(0)};
      end
   end

   // Queue empty flags
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_cmdq_empty <= 1'b1;
         o_evtq_empty <= 1'b1;
      end else begin
         o_cmdq_empty <= cmdq_prod == cmdq_cons;
         o_evtq_empty <= evtq_prod == evtq_cons;
      end
   end

   // Read data, one cycle after the strobe; unmapped reads zero
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_rdata <= 32'h0;
      end else if (i_rd) begin
         unique case (i_addr)
            `OFS_CONTROL_ZERO: o_rdata <= control_zero;
            `OFS_CONTROL_ACK: o_rdata <= control_ack;
            `OFS_SECURE_INIT: o_rdata <= {31'h0, inv_everything & sec_ok};
            `OFS_STATUS: o_rdata <= {27'h0, o_evtq_empty, o_cmdq_empty,
               cmd_refused, sync_done, inv_everything};
            `OFS_CMDQ_PROD: o_rdata <= 32'(cmdq_prod);
            `OFS_CMDQ_CONS: o_rdata <= 32'(cmdq_cons);
            `OFS_EVTQ_PROD: o_rdata <= 32'(evtq_prod);
            `OFS_EVTQ_CONS: o_rdata <= 32'(evtq_cons);
            `OFS_STE_LO: o_rdata <= ste_lo;
            `OFS_STE_HI: o_rdata <= {16'h0, ste_hi};
            `OFS_CD_WORD: o_rdata <= cd_word;
            `OFS_DECODE: o_rdata <= {22'h0, walk_share, walk_outer,
               walk_inner, granule, mode};
            default: o_rdata <= 32'h0;
         endcase
      end else begin
         o_rdata <= 32'h0;
      end
   end
endmodule

/* translation_unit_init_config_monitor.sv */
// Port-level assertions for the translation unit init block
`timescale 1ns/10ps
`include "xlate_init_consts.svh"
module translation_unit_init_config_monitor #(
   parameter int ID_W = 16
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_sec_override,
   input wire logic i_access_secure,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic [ID_W-1:0] i_stream_id,
   input wire logic [ID_W-1:0] i_substream_id,
   input wire logic [ID_W+5:0] o_ste_addr,
   input wire logic [ID_W+5:0] o_cd_addr,
   input wire logic o_abort,
   input wire logic o_stage1_en,
   input wire logic o_stage2_en,
   input wire logic o_cd_ptr_ipa,
   input wire logic o_af_fault_suppress,
   input wire logic [15:0] o_vm_tag,
   input wire logic o_flush_walk_cache,
   input wire logic o_flush_buffer_units
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   logic st_wr;
   logic init_wr;
   logic [15:0] vm_exp;
   // Strobes for stream entry and invalidate-everything writes
   assign st_wr = i_wr && i_addr == `OFS_STE_LO;
   assign init_wr = i_wr && i_addr == `OFS_SECURE_INIT && i_wdata[0];
   // Last stream entry high word, for the tag check
   always_ff @(posedge i_clock) begin
      if (i_wr && i_addr == `OFS_STE_HI) begin
         vm_exp <= i_wdata[15:0];
      end
   end
   a_ste_addr_scale: assert property (
      !$past(i_rst) |-> o_ste_addr == {$past(i_stream_id), 6'h00})
      else $error("stream entry address is not id times 64");
   a_cd_addr_scale: assert property (
      !$past(i_rst) |-> o_cd_addr == {$past(i_substream_id), 6'h00})
      else $error("descriptor address is not id times 64");
   a_abort_blocks_all: assert property (
      o_abort |-> !o_stage1_en && !o_stage2_en)
      else $error("stage enabled while aborting");
   a_abort_on_cfg: assert property (
      st_wr && !i_wdata[3] |-> ##2 o_abort)
      else $error("no abort after non-translating config");
   a_stage2_decode: assert property (
      st_wr && i_wdata[3:2] == 2'b11 |-> ##2 o_stage2_en && !o_abort)
      else $error("stage 2 not enabled by config");
   a_ipa_follows_s2: assert property (
      o_cd_ptr_ipa == o_stage2_en)
      else $error("pointer kind does not follow stage 2");
   a_af_suppress: assert property (
      st_wr && i_wdata[19] |-> ##2 o_af_fault_suppress)
      else $error("access flag suppress not set");
   a_vm_tag_load: assert property (
      i_wr && i_addr == `OFS_STE_HI |-> ##2 o_vm_tag == vm_exp)
      else $error("vm tag differs from written value");
   a_flush_pair: assert property (
      o_flush_walk_cache == o_flush_buffer_units)
      else $error("walk and buffer flushes differ");
   a_init_refused: assert property (
      init_wr && !i_access_secure && !i_sec_override && !o_flush_walk_cache
      |-> ##1 !o_flush_walk_cache [*4])
      else $error("refused init write started a flush");
   a_inv_start: assert property (
      init_wr && (i_access_secure || i_sec_override) && !o_flush_walk_cache
      |-> ##[1:3] o_flush_walk_cache ##1 o_flush_walk_cache [*8])
      else $error("invalidate-everything did not flush");
   a_inv_ends: assert property (
      $rose(o_flush_walk_cache) |-> ##[1:40] !o_flush_walk_cache)
      else $error("flush never finished");
endmodule
bind translation_unit_init_config translation_unit_init_config_monitor
   #(.ID_W(ID_W)) i_translation_unit_init_config_monitor (.i_clock, .i_rst,
   .i_sec_override, .i_access_secure, .i_addr, .i_wdata, .i_wr, .i_stream_id,
   .i_substream_id, .o_ste_addr, .o_cd_addr, .o_abort, .o_stage1_en,
   .o_stage2_en, .o_cd_ptr_ipa, .o_af_fault_suppress, .o_vm_tag,
   .o_flush_walk_cache, .o_flush_buffer_units);

/* translation_unit_init_config_tb_top.sv */
// Self-checking bench for the translation unit init block
`timescale 1ns/10ps
`include "xlate_init_consts.svh"
module translation_unit_init_config_tb_top;
   typedef struct {
      logic [2:0] cfg;
      logic [1:0] tg, ir, orr, sh;
      logic [4:0] cdmax;
      logic affd;
      logic [15:0] vmid;
      logic [2:0] exp;
   } row_s;
   logic i_clock, i_rst, i_sec_override, i_access_secure, i_wr, i_rd;
   logic [7:0] i_addr;
   logic [31:0] i_wdata, o_rdata, d;
   logic [15:0] i_stream_id, i_substream_id, o_vm_tag;
   logic [21:0] o_ste_addr, o_cd_addr;
   logic o_abort, o_stage1_en, o_stage2_en, o_walk0_en, o_cd_is_table;
   logic o_cd_ptr_ipa, o_af_fault_suppress, o_flush_walk_cache;
   logic o_flush_buffer_units, o_cmdq_empty, o_evtq_empty;
   int mismatches = 0;
   int total_checks = 0;
   int n;
   row_s r;
   // Ordinary cases: config, attribute fields, expected {abort,s1,s2}
   row_s rows [8] = '{
      '{3'b000, 2'd0, 2'd0, 2'd0, 2'd0, 5'd0, 1'b0, 16'h0000, 3'b100},
      '{3'b100, 2'd1, 2'd1, 2'd1, 2'd1, 5'd1, 1'b1, 16'h1234, 3'b000},
      '{3'b101, 2'd2, 2'd2, 2'd2, 2'd2, 5'd31, 1'b0, 16'hffff, 3'b010},
      '{3'b110, 2'd3, 2'd3, 2'd3, 2'd3, 5'd0, 1'b1, 16'h0001, 3'b001},
      '{3'b111, 2'd0, 2'd1, 2'd2, 2'd0, 5'd2, 1'b0, 16'h8000, 3'b011},
      '{3'b001, 2'd1, 2'd0, 2'd1, 2'd2, 5'd4, 1'b1, 16'h00ff, 3'b100},
      '{3'b010, 2'd2, 2'd1, 2'd0, 2'd1, 5'd0, 1'b0, 16'h0f0f, 3'b100},
      '{3'b011, 2'd0, 2'd2, 2'd1, 2'd0, 5'd8, 1'b1, 16'h5a5a, 3'b100}};
   logic [15:0] ids [2] = '{16'h0005, 16'hffff};
   logic [31:0] cdw [4] = '{32'h0, 32'h1, 32'h5, 32'h9};
   logic [1:0] cdx [4] = '{2'b00, 2'b11, 2'b01, 2'b11};
   logic [7:0] ops [4] = '{`OP_TLB_NS_EL1, `OP_TLB_HYP, `OP_TLB_MON,
      `OP_TLB_S_EL1};
   logic [7:0] qa [4] = '{`OFS_CMDQ_PROD, `OFS_EVTQ_PROD, `OFS_CMDQ_CONS,
      `OFS_EVTQ_CONS};
   logic [31:0] qd [4] = '{32'h3, 32'h5, 32'h3, 32'h5};
   logic [1:0] qe [4] = '{2'b01, 2'b00, 2'b10, 2'b11};

   translation_unit_init_config i_translation_unit_init_config (.i_clock,
      .i_rst, .i_sec_override, .i_access_secure, .i_addr, .i_wdata, .i_wr,
      .i_rd, .o_rdata, .i_stream_id, .i_substream_id, .o_ste_addr,
      .o_cd_addr, .o_abort, .o_stage1_en, .o_stage2_en, .o_walk0_en,
      .o_cd_is_table, .o_cd_ptr_ipa, .o_af_fault_suppress, .o_vm_tag,
      .o_flush_walk_cache, .o_flush_buffer_units, .o_cmdq_empty,
      .o_evtq_empty);

   // Free-running 250 MHz clock
   always #2 i_clock = ~i_clock;

   function automatic logic [1:0] fx(input logic [1:0] v);
      return (v == 2'b11) ? 2'b00 : v;
   endfunction
   task chk(input string what, input logic [31:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 v = o_rdata;
   endtask
   // Bounded register poll until the masked value matches
   task poll(input logic [7:0] a, input logic [31:0] m, e);
      for (int k = 0; k < 40; k++) begin
         rd(a, d);
         if ((d & m) === e) break;
      end
      chk("polled register", e, d & m);
   endtask
   // Counts flush-high cycles over a 60-cycle window
   task flush_len(output int len);
      len = 0;
      repeat (60) begin
         #1 if (o_flush_walk_cache === 1'b1) len++;
         @(posedge i_clock);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Watchdog: whole run needs a few hundred cycles, allow 20000
   initial begin
      #80000;
      mismatches++;
      report_and_stop;
   end

   // Main sequence
   initial begin
      {i_clock, i_rst, i_sec_override, i_access_secure, i_wr, i_rd} = 6'h10;
      {i_addr, i_wdata, i_stream_id, i_substream_id} = '0;
      repeat (16) @(posedge i_clock);
      i_rst <= 1'b0;
      wr(`OFS_CD_WORD, 32'h1);
      foreach (rows[i]) begin
         r = rows[i];
         wr(`OFS_STE_HI, {16'h0, r.vmid});
         wr(`OFS_STE_LO, {12'h0, r.affd, r.sh, r.orr, r.ir, r.tg, r.cdmax,
            2'b00, r.cfg, 1'b0});
         rd(`OFS_DECODE, d);
         chk("stage outs", {28'h0, r.exp, r.exp[0]}, {28'h0, o_abort,
            o_stage1_en, o_stage2_en, o_cd_ptr_ipa});
         chk("fields", {14'h0, r.cdmax != 0, r.affd, r.vmid}, {14'h0,
            o_cd_is_table, o_af_fault_suppress, o_vm_tag});
         chk("decode reg", {22'h0, fx(r.sh), fx(r.orr), fx(r.ir), r.tg,
            2'b00}, d & 32'h3fc);
         $display("row %0d done", i);
      end
      foreach (ids[i]) begin
         i_stream_id <= ids[i];
         i_substream_id <= ~ids[i];
         @(posedge i_clock);
         @(posedge i_clock);
         #1 chk("ste addr", {10'h0, ids[i], 6'h0}, {10'h0, o_ste_addr});
         chk("cd addr", {10'h0, ~ids[i], 6'h0}, {10'h0, o_cd_addr});
      end
      $display("address test done");
      wr(`OFS_STE_LO, 32'h0000000a);
      foreach (cdw[i]) begin
         wr(`OFS_CD_WORD, cdw[i]);
         @(posedge i_clock);
         #1 chk("cd use", {30'h0, cdx[i]}, {30'h0, o_walk0_en, o_stage1_en});
      end
      $display("descriptor test done");
      wr(`OFS_SECURE_INIT, 32'h1);
      flush_len(n);
      chk("refused flush", 32'h0, n);
      rd(`OFS_SECURE_INIT, d);
      chk("refused init bit", 32'h0, d);
      i_sec_override <= 1'b1;
      wr(`OFS_SECURE_INIT, 32'h1);
      flush_len(n);
      chk("override flush len", `INV_CYCLES, n);
      rd(`OFS_SECURE_INIT, d);
      chk("init bit cleared", 32'h0, d);
      i_sec_override <= 1'b0;
      i_access_secure <= 1'b1;
      wr(`OFS_SECURE_INIT, 32'h1);
      rd(`OFS_SECURE_INIT, d);
      chk("init bit busy", 32'h1, d & 32'h1);
      poll(`OFS_SECURE_INIT, 32'h1, 32'h0);
      $display("invalidate test done");
      foreach (ops[i]) wr(`OFS_CMD_SUBMIT, {23'h0, 1'b1, ops[i]});
      rd(`OFS_STATUS, d);
      chk("secure cmds accepted", 32'h0, d & 32'h4);
      i_access_secure <= 1'b0;
      wr(`OFS_CMD_SUBMIT, {24'h0, `OP_TLB_S_EL1});
      rd(`OFS_STATUS, d);
      chk("ns secure cmd refused", 32'h4, d & 32'h4);
      wr(`OFS_CMD_SUBMIT, {24'h0, `OP_CFG_INVALIDATE_EVERYTHING_BIT});
      flush_len(n);
      chk("cfgi pulse", 32'h1, n);
      wr(`OFS_CMD_SUBMIT, {24'h0, `OP_CFG_INVALIDATE_EVERYTHING_BIT});
      wr(`OFS_CMD_SUBMIT, {24'h0, `OP_SYNC});
      poll(`OFS_STATUS, 32'h2, 32'h2);
      $display("command test done");
      wr(`OFS_CONTROL_ZERO, 32'hd);
      poll(`OFS_CONTROL_ACK, 32'hd, 32'hd);
      foreach (qa[i]) begin
         wr(qa[i], qd[i]);
         for (n = 0; n < 8 && {o_cmdq_empty, o_evtq_empty} !== qe[i]; n++)
            @(posedge i_clock);
         chk("queue empty", {30'h0, qe[i]}, {30'h0, o_cmdq_empty,
            o_evtq_empty});
      end
      $display("enable and queue test done");
      wr(`OFS_CMDQ_PROD, 32'h7);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clock);
      i_rst <= 1'b0;
      #1 chk("reset outs", 32'h38, {26'h0, o_abort, o_cmdq_empty,
         o_evtq_empty, o_stage1_en, o_stage2_en, o_flush_walk_cache});
      rd(`OFS_CONTROL_ACK, d);
      chk("ack after reset", 32'h0, d);
      $display("reset test done");
      report_and_stop;
   end
endmodule
